//--- hdl/tpg_regs.vh
// Register map, field widths and reset values of the three-port GPIO block.
// Assumes a 32-bit AXI4-Lite slave; printed offsets are indices, byte address = 4 * index.
`ifndef TPG_REGS_VH
`define TPG_REGS_VH

// Printed register indices
`define TPG_IDX_FIRST_LATCH      8'h00
`define TPG_IDX_SECOND_LATCH     8'h01
`define TPG_IDX_THIRD_LATCH      8'h02
// Indices with no printed offset
`define TPG_IDX_FIRST_DIR        8'h04
`define TPG_IDX_SECOND_DIR       8'h05
`define TPG_IDX_THIRD_DIR        8'h06
`define TPG_IDX_FIRST_PULLUP     8'h08
`define TPG_IDX_THIRD_PULLUP     8'h09
`define TPG_IDX_KEY_ENABLES      8'h0a
`define TPG_IDX_ANALOG_SELECT    8'h0b

// Field widths
`define TPG_WIDE_W               8
`define TPG_NARROW_W             7
`define TPG_ASEL_W               5

// Reset values
`define TPG_DIR_RST              8'h00
`define TPG_PULLUP_RST           8'h00
`define TPG_KEY_RST              8'h00
`define TPG_ASEL_RST             5'h1f

// Answer codes
`define TPG_RESP_OKAY            2'b00
`define TPG_RESP_SLVERR          2'b10

`endif

//--- hdl/tpg_pin_sync.v
// Three-stage synchroniser for a group of package pins.
// Assumes asynchronous pin levels; output is the agreed level of stages two and three.
`timescale 1ns/1ns

module tpg_pin_sync #(
    parameter WIDTH = 8
) (
    input  wire             i_clk,
    input  wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_level
);
    reg [WIDTH-1:0] stage1_reg;
    reg [WIDTH-1:0] stage2_reg;
    reg [WIDTH-1:0] stage3_reg;
    reg [WIDTH-1:0] level_reg;

    // Stage one feeds stage two only
    always @(posedge i_clk) begin
        stage1_reg <= i_async;
        stage2_reg <= stage1_reg;
        stage3_reg <= stage2_reg;
    end

    // A bit changes only when stages two and three agree
    genvar b;
    generate
        for (b = 0; b < WIDTH; b = b + 1) begin : g_bit
            always @(posedge i_clk) begin
                if (stage2_reg[b] == stage3_reg[b]) begin
                    level_reg[b] <= stage3_reg[b];
                end
            end
        end
    endgenerate

    assign o_level = level_reg;
endmodule // tpg_pin_sync

//--- hdl/tpg_gpio.v
// Three-port GPIO block: latches, directions, pullups, analog claim and key enables.
// Assumes an AXI4-Lite master on I_CLOCK and pad cells that take out, enable and pullup.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ns
`include "tpg_regs.vh"

// Overview of operation
// - Data latches per pin, untouched by reset
// - Direction one drives pin unless analog-claimed, zero inputs
// - Reset clears all direction bits
// - Output pins read back latch value
// - Input pins read back sampled level
// - Latch writes always land, inputs unaffected
// - Direction registers fully readable and writable
// - Pullup on when enabled and input
// - Output direction kills pullup at once
// - Second port has no pullups
// - Analog select claims second-port pin
// - Unselected second-port pins stay digital
// - Key enables route first-port pins out
module tpg_gpio (
    input  wire        I_CLOCK,
    input  wire        I_SYS_RST,
    // AXI4-Lite slave
    input  wire [31:0] I_AWADDR,
    input  wire        I_AWVALID,
    output wire        O_AWREADY,
    input  wire [31:0] I_WDATA,
    input  wire [3:0]  I_WSTRB,
    input  wire        I_WVALID,
    output wire        O_WREADY,
    output wire [1:0]  O_BRESP,
    output wire        O_BVALID,
    input  wire        I_BREADY,
    input  wire [31:0] I_ARADDR,
    input  wire        I_ARVALID,
    output wire        O_ARREADY,
    output wire [31:0] O_RDATA,
    output wire [1:0]  O_RRESP,
    output wire        O_RVALID,
    input  wire        I_RREADY,
    // First port pins
    input  wire [7:0]  I_FIRST_PIN,
    output wire [7:0]  O_FIRST_PIN,
    output wire [7:0]  O_FIRST_PIN_OE,
    output wire [7:0]  O_FIRST_PULLUP,
    output wire [7:0]  O_KEY_INPUTS,
    output wire [7:0]  O_KEY_INTERRUPT_PIN_ENABLES,
    // Second port pins
    input  wire [7:0]  I_SECOND_PIN,
    output wire [7:0]  O_SECOND_PIN,
    output wire [7:0]  O_SECOND_PIN_OE,
    output wire [7:0]  O_ANALOG_CHANNEL_PINS,
    // Third port pins
    input  wire [6:0]  I_THIRD_PIN,
    output wire [6:0]  O_THIRD_PIN,
    output wire [6:0]  O_THIRD_PIN_OE,
    output wire [6:0]  O_THIRD_PULLUP
);
    localparam WA = `TPG_WIDE_W;
    localparam WC = `TPG_NARROW_W;
    // Full-byte reset values, cut to width where a port is narrower
    localparam [WA-1:0] DIR_RST = `TPG_DIR_RST;
    localparam [WA-1:0] PUE_RST = `TPG_PULLUP_RST;

    reg  [WA-1:0] first_port_latch_reg;
    reg  [WA-1:0] second_port_latch_reg;
    reg  [WC-1:0] third_port_latch_reg;
    reg  [WA-1:0] first_port_direction_reg;
    reg  [WA-1:0] second_port_direction_reg;
    reg  [WC-1:0] third_port_direction_reg;
    reg  [WA-1:0] first_port_pullup_enable_reg;
    reg  [WC-1:0] third_port_pullup_enable_reg;
    reg  [WA-1:0] key_interrupt_pin_enables_reg;
    reg  [`TPG_ASEL_W-1:0] analog_select_reg;

    reg           aw_held_reg;
    reg  [31:0]   aw_addr_reg;
    reg           w_held_reg;
    reg  [31:0]   w_data_reg;
    reg  [3:0]    w_strb_reg;
    reg           bvalid_reg;
    reg  [1:0]    bresp_reg;
    reg           rvalid_reg;
    reg  [1:0]    rresp_reg;
    reg  [31:0]   rdata_reg;
    reg  [31:0]   rdata_next;
    reg           rd_hit;
    reg           wr_hit;

    wire [WA-1:0] first_level;
    wire [WA-1:0] second_level;
    wire [WC-1:0] third_level;
    wire [WA-1:0] analog_claim;
    wire [WA-1:0] second_drive;
    wire          do_write;
    wire [7:0]    wr_idx;
    wire [7:0]    rd_idx;
    wire [7:0]    wr_byte;

    // Pins are asynchronous, so each group is synchronised
    tpg_pin_sync #(.WIDTH(WA)) u_sync_first (
        .i_clk   (I_CLOCK),
        .i_async (I_FIRST_PIN),
        .o_level (first_level)
    );
    tpg_pin_sync #(.WIDTH(WA)) u_sync_second (
        .i_clk   (I_CLOCK),
        .i_async (I_SECOND_PIN),
        .o_level (second_level)
    );
    tpg_pin_sync #(.WIDTH(WC)) u_sync_third (
        .i_clk   (I_CLOCK),
        .i_async (I_THIRD_PIN),
        .o_level (third_level)
    );

    // Address and data may arrive in either order; both held till response
    assign O_AWREADY = ~aw_held_reg & ~bvalid_reg;
    assign O_WREADY  = ~w_held_reg & ~bvalid_reg;
    assign do_write  = aw_held_reg & w_held_reg & ~bvalid_reg;
    assign wr_idx    = aw_addr_reg[9:2];
    assign wr_byte   = w_strb_reg[0] ? w_data_reg[7:0] : 8'h00;
    assign rd_idx    = I_ARADDR[9:2];

    always @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `TPG_RESP_OKAY;
            aw_addr_reg <= 32'h0000_0000;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
        end else begin
            if (I_AWVALID && O_AWREADY) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= I_AWADDR;
            end
            if (I_WVALID && O_WREADY) begin
                w_held_reg <= 1'b1;
                w_data_reg <= I_WDATA;
                w_strb_reg <= I_WSTRB;
            end
            if (do_write) begin
                bvalid_reg  <= 1'b1;
                bresp_reg   <= wr_hit ? `TPG_RESP_OKAY : `TPG_RESP_SLVERR;
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
            end else if (bvalid_reg && I_BREADY) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Write decode; unmapped or misaligned index gives SLVERR
    always @* begin
        wr_hit = (aw_addr_reg[1:0] == 2'b00) && (aw_addr_reg[31:10] == 22'h0) &&
                 ((wr_idx == `TPG_IDX_FIRST_LATCH)  || (wr_idx == `TPG_IDX_SECOND_LATCH) ||
                  (wr_idx == `TPG_IDX_THIRD_LATCH)  || (wr_idx == `TPG_IDX_FIRST_DIR) ||
                  (wr_idx == `TPG_IDX_SECOND_DIR)   || (wr_idx == `TPG_IDX_THIRD_DIR) ||
                  (wr_idx == `TPG_IDX_FIRST_PULLUP) || (wr_idx == `TPG_IDX_THIRD_PULLUP) ||
                  (wr_idx == `TPG_IDX_KEY_ENABLES)  || (wr_idx == `TPG_IDX_ANALOG_SELECT));
    end

    always @(posedge I_CLOCK) begin
        if (do_write && wr_hit && w_strb_reg[0]) begin
            if (wr_idx == `TPG_IDX_FIRST_LATCH) begin
                first_port_latch_reg <= wr_byte;
            end else if (wr_idx == `TPG_IDX_SECOND_LATCH) begin
                second_port_latch_reg <= wr_byte;
            end else if (wr_idx == `TPG_IDX_THIRD_LATCH) begin
                third_port_latch_reg <= wr_byte[WC-1:0];
            end
        end
    end

    // Control registers; only byte lane 0 carries data
    always @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            first_port_direction_reg      <= `TPG_DIR_RST;
            second_port_direction_reg     <= `TPG_DIR_RST;
            third_port_direction_reg      <= DIR_RST[WC-1:0];
            first_port_pullup_enable_reg  <= `TPG_PULLUP_RST;
            third_port_pullup_enable_reg  <= PUE_RST[WC-1:0];
            key_interrupt_pin_enables_reg <= `TPG_KEY_RST;
            analog_select_reg             <= `TPG_ASEL_RST;
        end else if (do_write && wr_hit && w_strb_reg[0]) begin
            if (wr_idx == `TPG_IDX_FIRST_DIR) begin
                first_port_direction_reg <= wr_byte;
            end else if (wr_idx == `TPG_IDX_SECOND_DIR) begin
                second_port_direction_reg <= wr_byte;
            end else if (wr_idx == `TPG_IDX_THIRD_DIR) begin
                third_port_direction_reg <= wr_byte[WC-1:0];
            end else if (wr_idx == `TPG_IDX_FIRST_PULLUP) begin
                first_port_pullup_enable_reg <= wr_byte;
            end else if (wr_idx == `TPG_IDX_THIRD_PULLUP) begin
                third_port_pullup_enable_reg <= wr_byte[WC-1:0];
            end else if (wr_idx == `TPG_IDX_KEY_ENABLES) begin
                key_interrupt_pin_enables_reg <= wr_byte;
            end else if (wr_idx == `TPG_IDX_ANALOG_SELECT) begin
                analog_select_reg <= wr_byte[`TPG_ASEL_W-1:0];
            end
        end
    end

    // Read mux: per bit, latch when output, synchronised pin when input
    always @* begin
        rdata_next = 32'h0000_0000;
        rd_hit     = (I_ARADDR[1:0] == 2'b00) && (I_ARADDR[31:10] == 22'h0);
        if (rd_idx == `TPG_IDX_FIRST_LATCH) begin
            rdata_next[WA-1:0] = (first_port_direction_reg & first_port_latch_reg) |
                                 (~first_port_direction_reg & first_level);
        end else if (rd_idx == `TPG_IDX_SECOND_LATCH) begin
            rdata_next[WA-1:0] = (second_port_direction_reg & second_port_latch_reg) |
                                 (~second_port_direction_reg & second_level);
        end else if (rd_idx == `TPG_IDX_THIRD_LATCH) begin
            rdata_next[WC-1:0] = (third_port_direction_reg & third_port_latch_reg) |
                                 (~third_port_direction_reg & third_level);
        end else if (rd_idx == `TPG_IDX_FIRST_DIR) begin
            rdata_next[WA-1:0] = first_port_direction_reg;
        end else if (rd_idx == `TPG_IDX_SECOND_DIR) begin
            rdata_next[WA-1:0] = second_port_direction_reg;
        end else if (rd_idx == `TPG_IDX_THIRD_DIR) begin
            rdata_next[WC-1:0] = third_port_direction_reg;
        end else if (rd_idx == `TPG_IDX_FIRST_PULLUP) begin
            rdata_next[WA-1:0] = first_port_pullup_enable_reg;
        end else if (rd_idx == `TPG_IDX_THIRD_PULLUP) begin
            rdata_next[WC-1:0] = third_port_pullup_enable_reg;
        end else if (rd_idx == `TPG_IDX_KEY_ENABLES) begin
            rdata_next[WA-1:0] = key_interrupt_pin_enables_reg;
        end else if (rd_idx == `TPG_IDX_ANALOG_SELECT) begin
            rdata_next[`TPG_ASEL_W-1:0] = analog_select_reg;
        end else begin
            rd_hit = 1'b0;
        end
        if (!rd_hit) begin
            rdata_next = 32'h0000_0000;
        end
    end

    // One read at a time; ARREADY low while data waits
    assign O_ARREADY = ~rvalid_reg;

    always @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            rvalid_reg <= 1'b0;
            rresp_reg  <= `TPG_RESP_OKAY;
            rdata_reg  <= 32'h0000_0000;
        end else if (I_ARVALID && O_ARREADY) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= rd_hit ? `TPG_RESP_OKAY : `TPG_RESP_SLVERR;
            rdata_reg  <= rdata_next;
        end else if (rvalid_reg && I_RREADY) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign O_BVALID = bvalid_reg;
    assign O_BRESP  = bresp_reg;
    assign O_RVALID = rvalid_reg;
    assign O_RRESP  = rresp_reg;
    assign O_RDATA  = rdata_reg;

    // Per-pin decode of analog channel; codes above 7 claim nothing
    genvar p;
    generate
        for (p = 0; p < WA; p = p + 1) begin : g_second
            // Channel code of this pin; a genvar cannot be part-selected
            localparam [31:0] CODE = p;
            assign analog_claim[p] = (analog_select_reg == CODE[`TPG_ASEL_W-1:0]);
            assign second_drive[p] = second_port_direction_reg[p] & ~analog_claim[p];
        end
    endgenerate

    assign O_FIRST_PIN      = first_port_latch_reg;
    assign O_FIRST_PIN_OE   = first_port_direction_reg;
    assign O_SECOND_PIN     = second_port_latch_reg;
    assign O_SECOND_PIN_OE  = second_drive;
    assign O_THIRD_PIN      = third_port_latch_reg;
    assign O_THIRD_PIN_OE   = third_port_direction_reg;

    // no pullup outputs on second port
    assign O_FIRST_PULLUP = first_port_pullup_enable_reg & ~first_port_direction_reg;
    assign O_THIRD_PULLUP = third_port_pullup_enable_reg & ~third_port_direction_reg;

    assign O_ANALOG_CHANNEL_PINS = analog_claim;

    assign O_KEY_INTERRUPT_PIN_ENABLES = key_interrupt_pin_enables_reg;
    assign O_KEY_INPUTS                = first_level & key_interrupt_pin_enables_reg;
endmodule // tpg_gpio

//--- test/tpg_pad_model.sv
// Board model of one port's pads: outside drivers, pullups, floating pins.
// Assumes the block's out, enable and pullup pins plus bench drive controls.
`timescale 1ns/1ns
module tpg_pad_model #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] oe,
    input  wire logic [W-1:0] dout,
    input  wire logic [W-1:0] pu,
    input  wire logic [W-1:0] ext_en,
    input  wire logic [W-1:0] ext_val,
    output logic      [W-1:0] lvl
);
    logic [W-1:0] flt_reg = '0;
    // A floating pin never keeps its old level, so stale reads show up
    always @(posedge clk) flt_reg <= ~lvl;
    // Pad level: block driver, outside driver, pullup, else floating
    always_comb begin
        for (int i = 0; i < W; i++) begin
            lvl[i] = oe[i] ? dout[i] : ext_en[i] ? ext_val[i] : pu[i] ? 1'b1 : flt_reg[i];
        end
    end
endmodule // tpg_pad_model

//--- test/tpg_gpio_asserts.sv
// Checker of pin and bus timing relations of the GPIO block.
// Assumes it is bound to tpg_gpio and sees its ports only.
`timescale 1ns/1ns
module tpg_gpio_asserts (
    input wire logic       I_CLOCK,
    input wire logic       I_SYS_RST,
    input wire logic       I_AWVALID,
    input wire logic       O_AWREADY,
    input wire logic       I_WVALID,
    input wire logic       O_WREADY,
    input wire logic       O_BVALID,
    input wire logic       I_ARVALID,
    input wire logic       O_ARREADY,
    input wire logic       O_RVALID,
    input wire logic [7:0] O_FIRST_PIN_OE,
    input wire logic [7:0] O_FIRST_PULLUP,
    input wire logic [7:0] O_SECOND_PIN_OE,
    input wire logic [7:0] O_ANALOG_CHANNEL_PINS,
    input wire logic [6:0] O_THIRD_PIN_OE,
    input wire logic [6:0] O_THIRD_PULLUP
);
    // One clock domain, so one default clock and reset
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (I_SYS_RST);

    a_first_pullup_gate: assert property ((O_FIRST_PULLUP & O_FIRST_PIN_OE) == 8'h00)
        else $error("pullup on driven first pin");
    a_third_pullup_gate: assert property ((O_THIRD_PULLUP & O_THIRD_PIN_OE) == 7'h00)
        else $error("pullup on driven third pin");
    a_claim_undriven: assert property ((O_ANALOG_CHANNEL_PINS & O_SECOND_PIN_OE) == 8'h00)
        else $error("claimed analog pin driven");
    a_claim_single: assert property ($onehot0(O_ANALOG_CHANNEL_PINS))
        else $error("more than one analog pin claimed");
    a_reset_inputs: assert property ($fell(I_SYS_RST) |-> O_FIRST_PIN_OE == 8'h00 && O_SECOND_PIN_OE == 8'h00
        && O_THIRD_PIN_OE == 7'h00 && O_FIRST_PULLUP == 8'h00) else $error("pins not inputs after reset");
    a_write_answer: assert property (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |=> !O_BVALID ##1 O_BVALID)
        else $error("write answer late or early");
    a_busy_no_take: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
        else $error("write taken while answer pending");
    a_read_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID && !O_ARREADY)
        else $error("read answer not next cycle");
endmodule // tpg_gpio_asserts

bind tpg_gpio tpg_gpio_asserts chk (.*);

//--- test/tb.sv
// Self-checking bench: AXI4-Lite register tasks, one task per scenario.
// Assumes tpg_gpio, its register header and a pad model on each port.
`timescale 1ns/1ns
`include "tpg_regs.vh"
module tb;
    logic        I_CLOCK, I_SYS_RST, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY;
    logic [31:0] I_AWADDR, I_WDATA, I_ARADDR;
    logic [3:0]  I_WSTRB;
    wire  [31:0] O_RDATA;
    wire  [1:0]  O_BRESP, O_RRESP;
    wire         O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
    wire  [7:0]  I_FIRST_PIN, O_FIRST_PIN, O_FIRST_PIN_OE, O_FIRST_PULLUP, O_KEY_INPUTS;
    wire  [7:0]  O_KEY_INTERRUPT_PIN_ENABLES, I_SECOND_PIN, O_SECOND_PIN, O_SECOND_PIN_OE;
    wire  [7:0]  O_ANALOG_CHANNEL_PINS;
    wire  [6:0]  I_THIRD_PIN, O_THIRD_PIN, O_THIRD_PIN_OE, O_THIRD_PULLUP;
    logic [7:0]  ae, av, be, bv;
    logic [6:0]  ce, cv;
    int          err_count = 0;
    int          tests_run = 0;
    int          cyc = 0;
    localparam logic [1:0] OK = `TPG_RESP_OKAY;
    localparam logic [1:0] ER = `TPG_RESP_SLVERR;
    logic [7:0]  lat_ix [3] = '{`TPG_IDX_FIRST_LATCH, `TPG_IDX_SECOND_LATCH, `TPG_IDX_THIRD_LATCH};
    logic [7:0]  dir_ix [3] = '{`TPG_IDX_FIRST_DIR, `TPG_IDX_SECOND_DIR, `TPG_IDX_THIRD_DIR};
    // third-port bits 6,5 never made outputs
    logic [7:0]  out_dir [3] = '{8'hff, 8'hff, 8'h1f};

    tpg_gpio uut (.*);
    tpg_pad_model #(.W(8)) pad_a (.clk(I_CLOCK), .oe(O_FIRST_PIN_OE), .dout(O_FIRST_PIN),
        .pu(O_FIRST_PULLUP), .ext_en(ae), .ext_val(av), .lvl(I_FIRST_PIN));
    tpg_pad_model #(.W(8)) pad_b (.clk(I_CLOCK), .oe(O_SECOND_PIN_OE), .dout(O_SECOND_PIN),
        .pu(8'h00), .ext_en(be), .ext_val(bv), .lvl(I_SECOND_PIN));
    tpg_pad_model #(.W(7)) pad_c (.clk(I_CLOCK), .oe(O_THIRD_PIN_OE), .dout(O_THIRD_PIN),
        .pu(O_THIRD_PULLUP), .ext_en(ce), .ext_val(cv), .lvl(I_THIRD_PIN));

    // 20 MHz bus clock
    initial begin
        I_CLOCK = 1'b0;
        forever #25 I_CLOCK = ~I_CLOCK;
    end

    // Hang guard far above the few hundred cycles needed
    always @(posedge I_CLOCK) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("tests_run=%0d err_count=%0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Pin-side results are bytes
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        chk({24'h0, got}, {24'h0, exp});
    endtask

    function automatic logic [7:0] pin_out(input int p);
        return p == 0 ? O_FIRST_PIN : p == 1 ? O_SECOND_PIN : {1'b0, O_THIRD_PIN};
    endfunction

    function automatic logic [7:0] pin_oe(input int p);
        return p == 0 ? O_FIRST_PIN_OE : p == 1 ? O_SECOND_PIN_OE : {1'b0, O_THIRD_PIN_OE};
    endfunction

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] ix, input logic [31:0] d, input logic [1:0] er);
        logic a, w, ha, hw;
        a = 1'b1;
        w = 1'b1;
        @(posedge I_CLOCK);
        I_AWADDR <= {22'h0, ix, 2'b00};
        I_WDATA <= d;
        {I_AWVALID, I_WVALID, I_BREADY} <= 3'h7;
        while (a | w) begin
            @(negedge I_CLOCK);
            ha = a & O_AWREADY;
            hw = w & O_WREADY;
            @(posedge I_CLOCK);
            a = a & ~ha;
            w = w & ~hw;
            I_AWVALID <= a;
            I_WVALID <= w;
        end
        do @(negedge I_CLOCK); while (!O_BVALID);
        chk({30'h0, O_BRESP}, {30'h0, er});
        @(posedge I_CLOCK);
        I_BREADY <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] ix, input logic [31:0] exp, input logic [1:0] er);
        @(posedge I_CLOCK);
        I_ARADDR <= {22'h0, ix, 2'b00};
        {I_ARVALID, I_RREADY} <= 2'h3;
        do @(negedge I_CLOCK); while (!O_ARREADY);
        @(posedge I_CLOCK);
        I_ARVALID <= 1'b0;
        do @(negedge I_CLOCK); while (!O_RVALID);
        chk(O_RDATA, exp);
        chk({30'h0, O_RRESP}, {30'h0, er});
        @(posedge I_CLOCK);
        I_RREADY <= 1'b0;
    endtask

    task automatic t_reset();
        for (int p = 0; p < 3; p++) rd(dir_ix[p], 32'h0, OK);
        rd(`TPG_IDX_FIRST_PULLUP, 32'h0, OK);
        rd(`TPG_IDX_THIRD_PULLUP, 32'h0, OK);
        rd(`TPG_IDX_KEY_ENABLES, 32'h0, OK);
        rd(`TPG_IDX_ANALOG_SELECT, {27'h0, `TPG_ASEL_RST}, OK);
        $display("reset values done");
    endtask

    task automatic t_out();
        for (int p = 0; p < 3; p++) begin
            // latch loaded before the driver turns on
            wr(lat_ix[p], 32'hffff_ff3c, OK);
            wr(dir_ix[p], {24'h0, out_dir[p]}, OK);
            chk8(pin_oe(p), out_dir[p]);
            chk8(pin_out(p) & out_dir[p], 8'h3c & out_dir[p]);
            rd(dir_ix[p], {24'h0, out_dir[p]}, OK);
            rd(lat_ix[p], p == 2 ? 32'h1c : 32'h3c, OK);
        end
        $display("output drive done");
    endtask

    // Mid-run reset: directions cleared, latches kept
    task automatic t_keep();
        @(posedge I_CLOCK);
        I_SYS_RST <= 1'b1;
        repeat (2) @(posedge I_CLOCK);
        I_SYS_RST <= 1'b0;
        for (int p = 0; p < 3; p++) begin
            chk8(pin_oe(p), 8'h00);
            wr(dir_ix[p], {24'h0, out_dir[p]}, OK);
            chk8(pin_out(p) & out_dir[p], 8'h3c & out_dir[p]);
        end
        $display("latch keep done");
    endtask

    task automatic t_in();
        @(posedge I_CLOCK);
        {ae, av, be, bv, ce, cv} <= {8'hff, 8'h16, 8'hff, 8'h16, 7'h7f, 7'h16};
        for (int p = 0; p < 3; p++) begin
            wr(dir_ix[p], 32'h0, OK);
            wr(lat_ix[p], 32'he9, OK);
            repeat (6) @(posedge I_CLOCK);
            rd(lat_ix[p], 32'h16, OK);
        end
        {ae, be, ce} <= {8'h00, 8'h00, 7'h60};
        for (int p = 0; p < 3; p++) begin
            wr(dir_ix[p], {24'h0, out_dir[p]}, OK);
            rd(lat_ix[p], p == 2 ? 32'h09 : 32'he9, OK);
        end
        $display("input read done");
    endtask

    task automatic t_pull();
        wr(`TPG_IDX_FIRST_DIR, 32'h0f, OK);
        wr(`TPG_IDX_FIRST_PULLUP, 32'hff, OK);
        chk8(O_FIRST_PULLUP, 8'hf0);
        repeat (6) @(posedge I_CLOCK);
        rd(`TPG_IDX_FIRST_LATCH, 32'hf9, OK);
        wr(`TPG_IDX_FIRST_DIR, 32'h0, OK);
        chk8(O_FIRST_PULLUP, 8'hff);
        wr(`TPG_IDX_FIRST_PULLUP, 32'h0, OK);
        chk8(O_FIRST_PULLUP, 8'h00);
        wr(`TPG_IDX_THIRD_DIR, 32'h0, OK);
        wr(`TPG_IDX_THIRD_PULLUP, 32'h7f, OK);
        repeat (6) @(posedge I_CLOCK);
        rd(`TPG_IDX_THIRD_LATCH, 32'h1f, OK);
        wr(`TPG_IDX_THIRD_DIR, 32'h1f, OK);
        chk8({1'b0, O_THIRD_PULLUP}, 8'h60);
        $display("pullups done");
    endtask

    task automatic t_analog();
        logic [4:0] sel [4] = '{5'h00, 5'h03, 5'h07, 5'h08};
        logic [7:0] cl;
        foreach (sel[i]) begin
            cl = sel[i] < 5'h08 ? 8'h01 << sel[i] : 8'h00;
            wr(`TPG_IDX_ANALOG_SELECT, {27'h0, sel[i]}, OK);
            chk8(O_ANALOG_CHANNEL_PINS, cl);
            chk8(O_SECOND_PIN_OE, ~cl);
        end
        $display("analog claim done");
    endtask

    task automatic t_key();
        @(posedge I_CLOCK);
        {ae, av} <= {8'hff, 8'h3c};
        wr(`TPG_IDX_KEY_ENABLES, 32'h5a, OK);
        repeat (6) @(posedge I_CLOCK);
        chk8(O_KEY_INTERRUPT_PIN_ENABLES, 8'h5a);
        chk8(O_KEY_INPUTS, 8'h18);
        $display("key inputs done");
    endtask

    task automatic t_err();
        wr(8'h03, 32'h55, ER);
        rd(8'h07, 32'h0, ER);
        $display("unmapped done");
    endtask

    // Reset, then the scenarios in order
    initial begin
        I_SYS_RST = 1'b1;
        {I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY} = 5'h00;
        {I_AWADDR, I_WDATA, I_ARADDR} = 96'h0;
        I_WSTRB = 4'hf;
        {ae, av, be, bv, ce, cv} = {32'h0, 7'h60, 7'h00};
        repeat (2) @(posedge I_CLOCK);
        I_SYS_RST <= 1'b0;
        t_reset();
        t_out();
        t_keep();
        t_in();
        t_pull();
        t_analog();
        t_key();
        t_err();
        give_verdict();
    end
endmodule // tb
